// ---- bench/t2cf_pin_model.sv ----
// t2cf_pin_model: oscillator and comparator pins driven into the block.
// assumes the bench gates each source; edges land well off the clock edge.
`timescale 1ns/1ps
module t2cf_pin_model
(
   input  wire logic clk_in,    // system clock
   input  wire logic rtc_on_in, // run oscillator
   input  wire logic cmp_on_in, // run comparator
   output logic      rtc_out,   // oscillator pin
   output logic      cmp_out    // comparator pin
);
   int n = 0;
   // a stopped source rests low so no stray edge reaches the synchronisers
   always @(posedge clk_in)
   begin
      #37;
      n++;
      rtc_out = rtc_on_in && (n % 6 < 3);
      cmp_out = cmp_on_in && (n % 10 < 5);
   end
endmodule : t2cf_pin_model

// ---- bench/t2cf_timer_bench.sv ----
// t2cf_timer_bench: directed tests of the timer 2 control block over its sfr ports.
// assumes the pin model supplies the oscillator and comparator inputs.
`timescale 1ns/1ps
module t2cf_timer_bench;
   logic        clk, rst, sfr_wr, sfr_rd, bit_wr, bit_d, ien, hsel, lsel, rtc, cmp, rtc_on, cmp_on, cap_wr, irq, f;
   logic [7:0]  addr, wdata, rdata, baddr, d;
   logic [15:0] rel, cnt, cap_d, c;
   int          err_total = 0, checked = 0, s;

   initial
   begin
      clk = 1'b0;
      forever #50 clk = ~clk;
   end

   t2cf_timer dut (.CLK_IN(clk), .RST_IN(rst), .SFR_ADDR_IN(addr), .SFR_WR_IN(sfr_wr), .SFR_RD_IN(sfr_rd),
      .SFR_WDATA_IN(wdata), .SFR_RDATA_OUT(rdata), .BIT_ADDR_IN(baddr), .BIT_WR_IN(bit_wr), .BIT_DATA_IN(bit_d),
      .TIMER_IRQ_EN_IN(ien), .HIGH_SYSTEM_CLOCK_SEL_IN(hsel), .LOW_SYSTEM_CLOCK_SEL_IN(lsel), .RELOAD_IN(rel), .RTC_IN(rtc),
      .CMP_IN(cmp), .COUNT_OUT(cnt), .CAPTURE_WR_OUT(cap_wr), .CAPTURE_DATA_OUT(cap_d), .IRQ_OUT(irq));
   t2cf_pin_model pins (.clk_in(clk), .rtc_on_in(rtc_on), .cmp_on_in(cmp_on), .rtc_out(rtc), .cmp_out(cmp));

   task automatic cyc(input int n);
      repeat (n) @(posedge clk);
      #10;
   endtask : cyc

   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      checked++;
      if (got !== exp)
      begin
         err_total++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk

   // every strobe task (rd, wrchk, bw) idles one cycle at the end so no strobe is set twice in a time step
   task automatic rd(input logic [7:0] a);
      addr = a;
      sfr_rd = 1'b1;
      cyc(1);
      sfr_rd = 1'b0;
      d = rdata;
      cyc(1);
   endtask : rd

   // write then read back on the next cycle; flag bits are left out as hardware may set them
   task automatic wrchk(input logic [7:0] v);
      addr = 8'hc8;
      wdata = v;
      sfr_wr = 1'b1;
      cyc(1);
      sfr_wr = 1'b0;
      sfr_rd = 1'b1;
      cyc(1);
      sfr_rd = 1'b0;
      chk(rdata & 8'h3f, v & 8'h3f);
      cyc(1);
   endtask : wrchk

   task automatic bw(input logic [2:0] b, input logic v);
      baddr = 8'hc8 | 8'(b);
      bit_d = v;
      bit_wr = 1'b1;
      cyc(1);
      bit_wr = 1'b0;
      cyc(1);
   endtask : bw

   task automatic wflag(input logic [7:0] m, input int lim);
      repeat (lim)
      begin
         rd(8'hc8);
         if ((d & m) != 8'h00) return;
      end
      chk(d, m);
      summarize();
   endtask : wflag

   task automatic wcap(input int lim, input logic exp);
      f = 1'b0;
      repeat (lim)
      begin
         cyc(1);
         f = (cap_wr === 1'b1);
         if (f) return;
      end
      // running out is a failure only when a capture was due
      if (exp)
      begin
         chk(f, exp);
         summarize();
      end
   endtask : wcap

   task automatic summarize;
      $display("checked=%0d err_total=%0d", checked, err_total);
      if (err_total == 0 && checked > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask : summarize

   initial
   begin
      {rst, sfr_wr, sfr_rd, bit_wr, bit_d, rtc_on, cmp_on} = 7'h40;
      {addr, wdata, baddr} = 24'h000000;
      {ien, hsel, lsel, rel} = {3'h7, 16'he0f0};
      cyc(4);
      rst = 1'b0;
      rd(8'hc8); chk(d, 8'h00);
      rd(8'hc9); chk(d, 8'h00);
      wrchk(8'h08);
      wflag(8'h40, 400);
      chk(cnt[15:8], 8'h00);
      chk(irq, 1'b0);
      chk(cnt[7:0] >= 8'hf0, 1'b1);
      bw(3'h5, 1'b1); chk(irq, 1'b1);
      wrchk(8'h0c);
      wflag(8'h80, 400); chk(irq, 1'b1);
      chk(cnt[15:8] >= 8'he0, 1'b1);
      wrchk(8'h00); c = cnt; cyc(20);
      chk(cnt, c); chk(irq, 1'b0);
      bw(3'h7, 1'b1); chk(irq, 1'b1);
      ien = 1'b0; cyc(1); chk(irq, 1'b0);
      ien = 1'b1;
      wrchk(8'h04); wflag(8'h80, 5000);
      chk(cnt >= 16'he0f0, 1'b1);
      rd(8'hc8); chk(d[6], 1'b1);
      lsel = 1'b0; wrchk(8'h04); c = cnt; cyc(120);
      chk(cnt - c, 16'h000a);
      wrchk(8'h05); c = cnt; cyc(60); chk(cnt, c);
      cmp_on = 1'b1; cyc(60); chk(cnt != c, 1'b1);
      cmp_on = 1'b0;
      hsel = 1'b0;
      wrchk(8'h0f); c = cnt; cyc(60); chk(cnt, c);
      rtc_on = 1'b1; cyc(120); chk(cnt - c, 16'h0202);
      rtc_on = 1'b0;
      hsel = 1'b1;
      for (s = 0; s < 6; s++) bw(3'(s), 1'b1);
      rd(8'hc8); chk(d & 8'h3f, 8'h3f);
      for (s = 0; s < 6; s++) bw(3'(s), 1'b0);
      rd(8'hc8); chk(d & 8'h3f, 8'h00);
      for (s = 0; s < 4; s++)
      begin
         wrchk(8'h10 | 8'(s));
         rtc_on = s[1]; cmp_on = !s[1]; wcap(100, 1'b0); chk(f, 1'b0);
         rtc_on = !s[1]; cmp_on = s[1]; wcap(200, 1'b1); chk(f, 1'b1);
         chk(cap_d, cnt);
         {rtc_on, cmp_on} = 2'b00; rd(8'hc8); chk(d[7], 1'b1);
      end
      summarize();
   end
endmodule : t2cf_timer_bench

// ---- bench/t2cf_timer_sva.sv ----
// t2cf_timer_sva: port-level checks for the timer 2 control block.
// assumes it is bound onto t2cf_timer and sees only its ports.
`timescale 1ns/1ps
module t2cf_timer_sva
(
   input wire logic        CLK_IN,           // clock
   input wire logic        RST_IN,           // reset
   input wire logic [7:0]  SFR_ADDR_IN,      // address
   input wire logic        SFR_WR_IN,        // write
   input wire logic        SFR_RD_IN,        // read
   input wire logic [7:0]  SFR_WDATA_IN,     // write data
   input wire logic [7:0]  SFR_RDATA_OUT,    // read data
   input wire logic        BIT_WR_IN,        // bit write
   input wire logic        TIMER_IRQ_EN_IN,  // irq enable
   input wire logic [15:0] COUNT_OUT,        // count
   input wire logic        CAPTURE_WR_OUT,   // capture pulse
   input wire logic [15:0] CAPTURE_DATA_OUT, // captured count
   input wire logic        IRQ_OUT           // irq
);
   default clocking cb @(posedge CLK_IN);
   endclocking
   default disable iff (RST_IN);

   a_read_idle: assert property (!(SFR_RD_IN && SFR_ADDR_IN == 8'hc8) |=> SFR_RDATA_OUT == 8'h00)
      else $error("read data not zero");
   a_write_read: assert property (SFR_WR_IN && SFR_ADDR_IN == 8'hc8 && !BIT_WR_IN ##1
      SFR_RD_IN && SFR_ADDR_IN == 8'hc8 && !SFR_WR_IN && !BIT_WR_IN
      |=> ((SFR_RDATA_OUT ^ $past(SFR_WDATA_IN, 2)) & 8'h3f) == 8'h00)
      else $error("written bits not read back");
   a_irq_gate: assert property (!TIMER_IRQ_EN_IN |-> !IRQ_OUT)
      else $error("irq without enable");
   a_irq_hold: assert property (IRQ_OUT && !SFR_WR_IN && !BIT_WR_IN ##1 TIMER_IRQ_EN_IN |-> IRQ_OUT)
      else $error("irq dropped without software");
   a_high_wrap: assert property ($past(COUNT_OUT) >= 16'hff00 && COUNT_OUT < 16'hff00 && TIMER_IRQ_EN_IN |-> IRQ_OUT)
      else $error("high wrap without irq");
   a_low_step: assert property (((COUNT_OUT ^ $past(COUNT_OUT)) & 16'h00ff) != 16'h0000 |->
      ((COUNT_OUT ^ ($past(COUNT_OUT) + 16'h0001)) & 16'h00ff) == 16'h0000 || ($past(COUNT_OUT) & 16'h00ff) == 16'h00ff)
      else $error("low byte jumped");
   a_cap_pulse: assert property (CAPTURE_WR_OUT |=> !CAPTURE_WR_OUT)
      else $error("capture pulse too long");
   a_cap_irq: assert property (CAPTURE_WR_OUT && TIMER_IRQ_EN_IN |-> IRQ_OUT)
      else $error("capture without irq");
   a_cap_data: assert property (CAPTURE_WR_OUT |-> CAPTURE_DATA_OUT == $past(COUNT_OUT))
      else $error("captured value wrong");
   a_cap_hold: assert property (!CAPTURE_WR_OUT |-> $stable(CAPTURE_DATA_OUT))
      else $error("captured value moved without trigger");

   c_capture: cover property (CAPTURE_WR_OUT);
   c_wrap: cover property ($past(COUNT_OUT) >= 16'hff00 && COUNT_OUT < 16'hff00);
   c_irq: cover property (IRQ_OUT);
endmodule : t2cf_timer_sva

bind t2cf_timer t2cf_timer_sva chk
(
   .CLK_IN           (CLK_IN),
   .RST_IN           (RST_IN),
   .SFR_ADDR_IN      (SFR_ADDR_IN),
   .SFR_WR_IN        (SFR_WR_IN),
   .SFR_RD_IN        (SFR_RD_IN),
   .SFR_WDATA_IN     (SFR_WDATA_IN),
   .SFR_RDATA_OUT    (SFR_RDATA_OUT),
   .BIT_WR_IN        (BIT_WR_IN),
   .TIMER_IRQ_EN_IN  (TIMER_IRQ_EN_IN),
   .COUNT_OUT        (COUNT_OUT),
   .CAPTURE_WR_OUT   (CAPTURE_WR_OUT),
   .CAPTURE_DATA_OUT (CAPTURE_DATA_OUT),
   .IRQ_OUT          (IRQ_OUT)
);

// ---- src/t2cf_pkg.sv ----
// t2cf_pkg: constants shared by the timer 2 control block and its tick source.
// assumes nothing beyond a single system clock domain.
package t2cf_pkg;

   localparam logic [7:0] CTRL_ADDR      = 8'hc8;  // control register and base bit address
   localparam logic [7:0] CTRL_RESET     = 8'h00;
   localparam logic [7:0] COUNT_RESET    = 8'h00;

   // control register field positions
   localparam int HIGH_FLAG_BIT   = 7;
   localparam int LOW_FLAG_BIT    = 6;
   localparam int LOW_IRQ_EN_BIT  = 5;
   localparam int CAPTURE_EN_BIT  = 4;
   localparam int SPLIT_BIT       = 3;
   localparam int RUN_BIT         = 2;
   localparam int ALT_SEL_MSB     = 1;
   localparam int ALT_SEL_LSB     = 0;

   // divider counts
   localparam int         SYS_DIV        = 12;
   localparam int         RTC_DIV        = 8;
   localparam logic [3:0] SYS_DIV_LAST   = 4'(SYS_DIV - 1);
   localparam logic [2:0] RTC_DIV_LAST   = 3'(RTC_DIV - 1);

   localparam logic [7:0]  BYTE_MAX      = 8'hff;
   localparam logic [15:0] WORD_MAX      = 16'hffff;

   typedef enum logic [1:0]
   {
      T2CF_ALT_DIV12_TRIG_RTC = 2'b00,
      T2CF_ALT_CMP_TRIG_RTC   = 2'b01,
      T2CF_ALT_DIV12_TRIG_CMP = 2'b10,
      T2CF_ALT_RTC_TRIG_CMP   = 2'b11
   } t2cf_alt_sel_t;

endpackage : t2cf_pkg

// ---- src/t2cf_tick_if.sv ----
// t2cf_tick_if: one-cycle tick enables from the source module to the timer control.
// assumes both ends run on the system clock.
`timescale 1ns/1ps
interface t2cf_tick_if;
   logic sys_div12_tick;  // system clock / 12
   logic rtc_div8_tick;   // every eighth synchronised oscillator rising edge
   logic cmp_rise_tick;   // synchronised comparator 0 rising edge

   modport src (output sys_div12_tick, output rtc_div8_tick, output cmp_rise_tick);
   modport use_side (input sys_div12_tick, input rtc_div8_tick, input cmp_rise_tick);
endinterface : t2cf_tick_if

// ---- src/t2cf_tick_src.sv ----
// t2cf_tick_src: synchronises the oscillator and comparator inputs and makes tick enables.
// assumes async pin inputs and one system clock with async active-high reset.
`timescale 1ns/1ps
module t2cf_tick_src
(
   input  wire logic  clk_in,     // system clock
   input  wire logic  rst_in,     // async reset, active high
   input  wire logic  rtc_in,     // low-frequency oscillator, async
   input  wire logic  cmp_in,     // comparator 0 output, async
   t2cf_tick_if.src   ticks       // tick enables out
);
   logic [2:0] rtc_sync;
   logic [2:0] cmp_sync;
   logic [3:0] sys_cnt;
   logic [2:0] rtc_cnt;
   logic [2:0] next_rtc_sync;
   logic [2:0] next_cmp_sync;
   logic [3:0] next_sys_cnt;
   logic [2:0] next_rtc_cnt;
   logic       rtc_rise;

   always_comb
   begin
      // stage 0 feeds only stage 1; edges are taken between stages 1 and 2
      next_rtc_sync = {rtc_sync[1:0], rtc_in};
      next_cmp_sync = {cmp_sync[1:0], cmp_in};
      rtc_rise      = rtc_sync[1] & ~rtc_sync[2];
      next_sys_cnt  = (sys_cnt == t2cf_pkg::SYS_DIV_LAST) ? 4'h0 : sys_cnt + 4'h1;
      next_rtc_cnt  = rtc_rise ? rtc_cnt + 3'h1 : rtc_cnt;
   end

   always_ff @(posedge clk_in or posedge rst_in)
   begin
      if (rst_in)
      begin
         rtc_sync <= 3'h0;
         cmp_sync <= 3'h0;
         sys_cnt  <= 4'h0;
         rtc_cnt  <= 3'h0;
      end
      else
      begin
         rtc_sync <= next_rtc_sync;
         cmp_sync <= next_cmp_sync;
         sys_cnt  <= next_sys_cnt;
         rtc_cnt  <= next_rtc_cnt;
      end
   end

   assign ticks.sys_div12_tick = (sys_cnt == t2cf_pkg::SYS_DIV_LAST);
   assign ticks.rtc_div8_tick  = rtc_rise & (rtc_cnt == t2cf_pkg::RTC_DIV_LAST);
   assign ticks.cmp_rise_tick  = cmp_sync[1] & ~cmp_sync[2];

endmodule : t2cf_tick_src

// ---- src/t2cf_timer.sv ----
// t2cf_timer: timer 2 control register, 16-bit / split 8-bit auto-reload counter and capture.
// assumes the cpu drives the sfr strobes on the system clock; reload bytes live outside.
//
// Overview of operation
// - high byte rolling from ff to 00 sets the high overflow flag.
// - in 16-bit mode the high flag sets on the ffff to 0000 wrap.
// - set high flag with timer interrupt enabled raises the interrupt request.
// - hardware never clears overflow flags; software clears them after service.
// - low byte rolling ff to 00 sets the low flag in either mode.
// - low flag interrupts only with low irq enable bit 5 and timer enable.
// - capture enable bit 4 set puts the timer into capture mode.
// - split bit 3 set gives two 8-bit reload timers, else one 16-bit.
// - 16-bit timer and split-mode high byte count only while run control bit 2 is one.
// - in split mode run control gates only the high byte timer.
// - in split mode the selector picks one alternate source for both bytes.
// - alternate count sources are synchronised to the system clock before use.
// - selector codes choose alternate clock and capture trigger per the encoding table.
// - control register sits at 0xc8 with single-bit read-modify-write access.
// - in 16-bit mode a wrap loads the 16-bit reload value into the counter.
// - capture trigger copies the count into the reload registers and sets high flag.
// - a byte's system clock select picks system clock, else the alternate source.
`timescale 1ns/1ps
module t2cf_timer
(
   input  wire logic        CLK_IN,              // system clock, 10 MHz
   input  wire logic        RST_IN,              // async reset, active high
   input  wire logic [7:0]  SFR_ADDR_IN,         // byte sfr address
   input  wire logic        SFR_WR_IN,           // byte write strobe
   input  wire logic        SFR_RD_IN,           // byte read strobe
   input  wire logic [7:0]  SFR_WDATA_IN,        // byte write data
   output logic      [7:0]  SFR_RDATA_OUT,       // read data, one cycle after read
   input  wire logic [7:0]  BIT_ADDR_IN,         // bit address
   input  wire logic        BIT_WR_IN,           // single-bit write strobe
   input  wire logic        BIT_DATA_IN,         // single-bit write value
   input  wire logic        TIMER_IRQ_EN_IN,     // timer interrupt enable from cpu
   input  wire logic        HIGH_SYSTEM_CLOCK_SEL_IN,  // high byte uses system clock
   input  wire logic        LOW_SYSTEM_CLOCK_SEL_IN,   // low byte (and 16-bit) uses system clock
   input  wire logic [15:0] RELOAD_IN,           // reload value, high:low
   input  wire logic        RTC_IN,              // low-frequency oscillator, async
   input  wire logic        CMP_IN,              // comparator 0 output, async
   output logic      [15:0] COUNT_OUT,           // counter value, high:low
   output logic             CAPTURE_WR_OUT,      // pulse: write capture data to reload
   output logic      [15:0] CAPTURE_DATA_OUT,    // captured count
   output logic             IRQ_OUT              // timer interrupt request, level
);
   t2cf_tick_if ticks ();

   t2cf_tick_src u_src
   (
      .clk_in (CLK_IN),
      .rst_in (RST_IN),
      .rtc_in (RTC_IN),
      .cmp_in (CMP_IN),
      .ticks  (ticks.src)
   );

   logic [7:0]  timer_two_control;
   logic [7:0]  next_control;
   logic [7:0]  count_high_byte;
   logic [7:0]  count_low_byte;
   logic [7:0]  next_high;
   logic [7:0]  next_low;
   logic        cap_wr;
   logic        next_cap_wr;
   logic [15:0] cap_data;
   logic [15:0] next_cap_data;
   logic [7:0]  rdata;
   logic [7:0]  next_rdata;

   logic        split_mode_select;
   logic        run_control;
   logic        capture_enable;
   logic [1:0]  alt_clock_select;
   logic        alt_tick;
   logic        trig_tick;
   logic        low_tick;
   logic        high_tick;
   logic        high_hw_set;
   logic        low_hw_set;
   logic [7:0]  sw_control;
   logic        ctrl_hit;
   logic [15:0] count_word;
   logic        low_at_max;
   logic        high_at_max;
   logic        word_at_max;

   assign split_mode_select = timer_two_control[t2cf_pkg::SPLIT_BIT];
   assign run_control       = timer_two_control[t2cf_pkg::RUN_BIT];
   assign capture_enable    = timer_two_control[t2cf_pkg::CAPTURE_EN_BIT];
   assign alt_clock_select  = timer_two_control[t2cf_pkg::ALT_SEL_MSB:t2cf_pkg::ALT_SEL_LSB];
   assign count_word        = {count_high_byte, count_low_byte};
   assign low_at_max        = (count_low_byte == t2cf_pkg::BYTE_MAX);
   assign high_at_max       = (count_high_byte == t2cf_pkg::BYTE_MAX);
   assign word_at_max       = (count_word == t2cf_pkg::WORD_MAX);

   // alternate source and capture trigger from the selector
   always_comb
   begin
      case (t2cf_pkg::t2cf_alt_sel_t'(alt_clock_select))
         t2cf_pkg::T2CF_ALT_DIV12_TRIG_RTC:
         begin
            alt_tick  = ticks.sys_div12_tick;
            trig_tick = ticks.rtc_div8_tick;
         end
         t2cf_pkg::T2CF_ALT_CMP_TRIG_RTC:
         begin
            alt_tick  = ticks.cmp_rise_tick;
            trig_tick = ticks.rtc_div8_tick;
         end
         t2cf_pkg::T2CF_ALT_DIV12_TRIG_CMP:
         begin
            alt_tick  = ticks.sys_div12_tick;
            trig_tick = ticks.cmp_rise_tick;
         end
         default:
         begin
            alt_tick  = ticks.rtc_div8_tick;
            trig_tick = ticks.cmp_rise_tick;
         end
      endcase
   end

   // counting and overflow; in 16-bit mode the low byte clock selection drives the whole word
   always_comb
   begin
      low_tick    = LOW_SYSTEM_CLOCK_SEL_IN | alt_tick;
      high_tick   = HIGH_SYSTEM_CLOCK_SEL_IN | alt_tick;
      next_high   = count_high_byte;
      next_low    = count_low_byte;
      high_hw_set = 1'b0;
      low_hw_set  = 1'b0;
      if (split_mode_select)
      begin
         if (low_tick)
         begin
            next_low   = low_at_max ? RELOAD_IN[7:0] : count_low_byte + 8'h01;
            low_hw_set = low_at_max;
         end
         if (run_control && high_tick)
         begin
            next_high   = high_at_max ? RELOAD_IN[15:8] : count_high_byte + 8'h01;
            high_hw_set = high_at_max;
         end
      end
      else if (run_control && low_tick)
      begin
         low_hw_set = low_at_max;
         if (word_at_max)
         begin
            {next_high, next_low} = RELOAD_IN;
            high_hw_set = 1'b1;
         end
         else
         begin
            {next_high, next_low} = count_word + 16'h0001;
         end
      end
      // capture is meant for 16-bit mode; software keeps split cleared
      next_cap_wr   = capture_enable & trig_tick;
      next_cap_data = cap_data;
      // the captured word holds until the next trigger, so it may be taken after the pulse
      if (next_cap_wr)
      begin
         next_cap_data = count_word;
         high_hw_set   = 1'b1;
      end
   end

   // control register: byte and bit writes, hardware sets win over software clears
   always_comb
   begin
      ctrl_hit   = (SFR_ADDR_IN == t2cf_pkg::CTRL_ADDR);
      sw_control = timer_two_control;
      if (SFR_WR_IN && ctrl_hit)
      begin
         sw_control = SFR_WDATA_IN;
      end
      if (BIT_WR_IN && (BIT_ADDR_IN[7:3] == t2cf_pkg::CTRL_ADDR[7:3]))
      begin
         sw_control[BIT_ADDR_IN[2:0]] = BIT_DATA_IN;
      end
      next_control = sw_control;
      // flags only ever leave one through software
      next_control[t2cf_pkg::HIGH_FLAG_BIT] = sw_control[t2cf_pkg::HIGH_FLAG_BIT] | high_hw_set;
      next_control[t2cf_pkg::LOW_FLAG_BIT]  = sw_control[t2cf_pkg::LOW_FLAG_BIT] | low_hw_set;
      // zero when not addressed, so several sources can be or-ed onto the cpu read path
      next_rdata = (SFR_RD_IN && ctrl_hit) ? timer_two_control : 8'h00;
   end

   always_ff @(posedge CLK_IN or posedge RST_IN)
   begin
      if (RST_IN)
      begin
         timer_two_control <= t2cf_pkg::CTRL_RESET;
         count_high_byte   <= t2cf_pkg::COUNT_RESET;
         count_low_byte    <= t2cf_pkg::COUNT_RESET;
         cap_wr            <= 1'b0;
         cap_data          <= 16'h0000;
         rdata             <= 8'h00;
      end
      else
      begin
         timer_two_control <= next_control;
         count_high_byte   <= next_high;
         count_low_byte    <= next_low;
         cap_wr            <= next_cap_wr;
         cap_data          <= next_cap_data;
         rdata             <= next_rdata;
      end
   end

   assign COUNT_OUT        = count_word;
   assign CAPTURE_WR_OUT   = cap_wr;
   assign CAPTURE_DATA_OUT = cap_data;
   assign SFR_RDATA_OUT    = rdata;
   // level request; it stays up until software clears the flag (or bit 5 for the low flag) or TIMER_IRQ_EN_IN drops
   assign IRQ_OUT = TIMER_IRQ_EN_IN &
                    (timer_two_control[t2cf_pkg::HIGH_FLAG_BIT] |
                     (timer_two_control[t2cf_pkg::LOW_FLAG_BIT] &
                      timer_two_control[t2cf_pkg::LOW_IRQ_EN_BIT]));

endmodule : t2cf_timer
